// ===== common/bus_seq_consts.vh
// Constants for the stack and indirect bus sequencer
`ifndef BUS_SEQ_CONSTS_VH
`define BUS_SEQ_CONSTS_VH
// Operation codes on the op_in port
`define OP_LONG_IND 4'h0
`define OP_JMP_IND 4'h1
`define OP_CALL_IND 4'h2
`define OP_RET_INT 4'h3
`define OP_RET_SHORT 4'h4
`define OP_RET_LONG 4'h5
`define OP_PUSH_IND 4'h6
`define OP_PUSH_REL 4'h7
`define OP_STACK_REL 4'h8
`define OP_INT_ENTRY 4'h9
// Cycle kinds from the step table
`define K_IDLE 3'h0
`define K_PROG 3'h1
`define K_DREAD 3'h2
`define K_DWRITE 3'h3
`define K_VECTOR 3'h4
`define K_END 3'h7
// Address source selectors
`define A_PC 4'h0
`define A_DP 4'h1
`define A_PTR 4'h2
`define A_SP 4'h3
`define A_SPUP 4'h4
`define A_PBIDX 4'h5
`define A_VEC 4'h6
`define A_NEWPC 4'h7
`define A_SPREL 4'h8
`define ZERO_BANK 8'h00
`endif

// ===== tb/bus_memory_model.sv
// Memory model answering the sequencer's bus cycles
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model (
  // Clock and bus
  input wire logic clk_in,
  input wire logic [23:0] addr_in,
  input wire logic read_write_n_in,
  input wire logic valid_data_address_in,
  input wire logic valid_program_address_in,
  // Returned byte
  output logic [7:0] rdata_out
);
  logic [7:0] last = 8'h00; // Byte shown in the previous cycle
  // Fixed contents, a pure function of the address
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'ha5;
  endfunction
  // Released bus flips each cycle so a stale byte never looks fresh
  always_comb begin
    if (read_write_n_in && (valid_data_address_in ||
        valid_program_address_in)) begin
      rdata_out = mem_byte(addr_in);
    end else begin
      rdata_out = ~last;
    end
  end
  // Remember what was shown
  always_ff @(posedge clk_in) begin
    last <= rdata_out;
  end
endmodule // bus_memory_model
`default_nettype wire

// ===== tb/cpu_stack_indirect_bus_sequencer_tb_top.sv
// Self-checking bench for the stack and indirect bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_consts.vh"
module cpu_stack_indirect_bus_sequencer_tb_top;
  logic clk_in, rst_n_in, start_in, native_in, wide_in, write_in;
  logic [3:0] op_in;
  logic [15:0] pc_in, sp_in, direct_base_in, index_in, vector_in;
  logic [7:0] program_bank_in, rdata_in, wdata_out;
  logic [23:0] addr_out;
  logic read_write_n_out, valid_data_address_out, valid_program_address_out;
  logic vector_pull_n_out, memory_lock_n_out, busy_out, done_out;
  logic [34:0] exp_q[$]; // Expected bus cycles, oldest first
  logic [34:0] got, want;
  logic [15:0] z, t, aa;
  logic [7:0] o;
  integer err_count = 0, n_compared = 0, cycles = 0, seed, i, k;
  cpu_stack_indirect_bus_sequencer cpu_stack_indirect_bus_sequencer_i (.*);
  bus_memory_model bus_memory_model_i (.clk_in(clk_in),
    .addr_in(addr_out), .read_write_n_in(read_write_n_out),
    .valid_data_address_in(valid_data_address_out),
    .valid_program_address_in(valid_program_address_out),
    .rdata_out(rdata_in));
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Memory contents as the model holds them
  function automatic logic [7:0] f(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'ha5;
  endfunction
  // Note one expected cycle; data checked only when chk is set
  task automatic ex(input logic [23:0] a, input logic rw, vpn, chk,
                    input logic [7:0] wd);
    exp_q.push_back({a, rw, vpn, chk, chk ? wd : 8'h00});
  endtask
  // Each qualified bus cycle takes the oldest note off the queue
  always @(negedge clk_in) begin
    if (rst_n_in && (valid_data_address_out || valid_program_address_out)) begin
      want = exp_q.size() ? exp_q.pop_front() : 35'h0;
      got = {addr_out, read_write_n_out, vector_pull_n_out, want[8],
             want[8] ? wdata_out : 8'h00};
      n_compared++;
      if (got !== want) begin
        err_count++;
        $display("ERROR %0t: cycle %h expected %h", $time, got, want);
      end
    end
  end
  // Note the cycles of one operation, start it, try a second start while busy
  task automatic run(input logic [3:0] op);
    pc_in = 16'($random(seed)) >> 1; // Kept clear of the 16-bit wrap
    sp_in = (16'($random(seed)) >> 1) + 16'h0010;
    direct_base_in = 16'($random(seed)) >> 1;
    index_in = 16'($random(seed)) >> 2;
    vector_in = 16'($random(seed)) >> 1;
    program_bank_in = 8'($random(seed));
    {native_in, wide_in, write_in} = 3'($random(seed));
    o = f({program_bank_in, pc_in + 16'h1});
    aa = {f({program_bank_in, pc_in + 16'h2}), o};
    if (op != `OP_INT_ENTRY) ex({program_bank_in, pc_in}, 1, 1, 0, 0);
    if (op <= `OP_CALL_IND || (op >= `OP_PUSH_IND && op <= `OP_STACK_REL))
      ex({program_bank_in, pc_in + 16'h1}, 1, 1, 0, 0);
    case (op)
      `OP_LONG_IND, `OP_PUSH_IND: begin
        z = direct_base_in + {8'h00, o};
        ex({8'h00, z}, 1, 1, 0, 0);
        ex({8'h00, z + 16'h1}, 1, 1, 0, 0);
        t = {f({8'h00, z + 16'h1}), f({8'h00, z})};
        if (op == `OP_PUSH_IND) begin
          ex({8'h00, sp_in}, 0, 1, 1, t[15:8]);
          ex({8'h00, sp_in - 16'h1}, 0, 1, 1, t[7:0]);
        end else begin
          ex({8'h00, z + 16'h2}, 1, 1, 0, 0);
          for (k = 0; k <= wide_in; k++)
            ex({f({8'h00, z + 16'h2}), t + k[15:0]}, ~write_in, 1, 0, 0);
        end
      end
      `OP_JMP_IND, `OP_CALL_IND: begin
        if (op == `OP_CALL_IND) begin
          t = pc_in + 16'h2; // Return counter: last operand byte
          ex({8'h00, sp_in}, 0, 1, 1, t[15:8]);
          ex({8'h00, sp_in - 16'h1}, 0, 1, 1, t[7:0]);
        end
        ex({program_bank_in, pc_in + 16'h2}, 1, 1, 0, 0);
        ex({program_bank_in, aa + index_in}, 1, 1, 0, 0);
        ex({program_bank_in, aa + index_in + 16'h1}, 1, 1, 0, 0);
      end
      `OP_RET_INT, `OP_RET_SHORT, `OP_RET_LONG: begin
        for (k = 1; k <= (op == `OP_RET_INT ? 4 : op - 2); k++)
          ex({8'h00, sp_in + k[15:0]}, 1, 1, 0, 0);
      end
      `OP_PUSH_REL: begin
        ex({program_bank_in, pc_in + 16'h2}, 1, 1, 0, 0);
        t = pc_in + 16'h3 + aa;
        ex({8'h00, sp_in}, 0, 1, 1, t[15:8]);
        ex({8'h00, sp_in - 16'h1}, 0, 1, 1, t[7:0]);
      end
      `OP_STACK_REL: begin
        t = sp_in + {8'h00, o};
        for (k = 0; k <= wide_in; k++)
          ex({8'h00, t + k[15:0]}, ~write_in, 1, 0, 0);
      end
      default: begin
        // Bank byte only in native mode; its slot is idle otherwise
        k = native_in;
        if (native_in) ex({8'h00, sp_in}, 0, 1, 1, program_bank_in);
        ex({8'h00, sp_in - k[15:0]}, 0, 1, 1, pc_in[15:8]);
        ex({8'h00, sp_in - k[15:0] - 16'h1}, 0, 1, 1, pc_in[7:0]);
        ex({8'h00, sp_in - k[15:0] - 16'h2}, 0, 1, 0, 0);
        ex({8'h00, vector_in}, 1, 0, 0, 0);
        ex({8'h00, vector_in + 16'h1}, 1, 0, 0, 0);
      end
    endcase
    op_in = op;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    repeat (3) @(negedge clk_in);
    if (busy_out === 1'b1) begin
      op_in = op + 4'h1; // Must be ignored while busy
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
    end
    for (k = 0; k < 60 && done_out !== 1'b1; k++) @(negedge clk_in);
    n_compared++;
    if (k == 60) begin
      err_count++;
      $display("ERROR %0t: no done for op %h", $time, op);
    end
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, well above 30 operations of at most 10 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      close_out();
    end
  end
  // Main sequence: all ten operations in turn, three rounds
  initial begin
    seed = 65676;
    {rst_n_in, start_in, native_in, wide_in, write_in} = 5'h00;
    {op_in, pc_in, sp_in, direct_base_in, index_in, vector_in} = 84'h0;
    program_bank_in = 8'h00;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (i = 0; i < 30; i++) run(4'(i % 10));
    repeat (4) @(negedge clk_in);
    n_compared++;
    if (exp_q.size() != 0) begin
      err_count++;
      $display("ERROR %0t: %0d cycles never seen", $time, exp_q.size());
    end
    close_out();
  end
endmodule // cpu_stack_indirect_bus_sequencer_tb_top
`default_nettype wire

// ===== tb/seq_bus_monitor.sv
// Checker for the stack and indirect bus sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_bus_monitor (
  // Clock, reset and request
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [3:0] op_in,
  input wire logic wide_in,
  input wire logic native_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] program_bank_in,
  input wire logic [15:0] sp_in,
  // Bus side
  input wire logic [23:0] addr_out,
  input wire logic read_write_n_out,
  input wire logic valid_data_address_out,
  input wire logic valid_program_address_out,
  input wire logic vector_pull_n_out,
  input wire logic memory_lock_n_out,
  input wire logic busy_out,
  input wire logic done_out
);
  logic [3:0] op; // Operation of the accepted start
  logic [15:0] pc, sp; // Counter and stack pointer at start
  logic [7:0] pb; // Program bank at start
  logic wide; // Operand width at start
  logic native; // Mode at start
  // Copy of what the block latches; a refused start leaves it alone
  always_ff @(posedge clk_in) begin
    if (start_in && !busy_out) begin
      op <= op_in;
      pc <= pc_in;
      sp <= sp_in;
      pb <= program_bank_in;
      wide <= wide_in;
      native <= native_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Internal cycle: address must be ignored outside
  sequence idle_c;
    !valid_data_address_out && !valid_program_address_out;
  endsequence
  // Opcode fetch at the program bank and counter
  sequence fetch_c;
    valid_data_address_out && valid_program_address_out &&
      read_write_n_out && addr_out == {pb, pc};
  endsequence
  // Stack access in bank zero
  sequence stk_c(logic rd, logic [15:0] a);
    valid_data_address_out && read_write_n_out == rd &&
      addr_out == {8'h00, a};
  endsequence
  begin_busy_a: assert property (start_in && !busy_out |=> busy_out)
    else $error("start not answered by busy");
  fetch_first_a: assert property (
    $rose(busy_out) && op != 4'h9 |=> fetch_c)
    else $error("first cycle is not the opcode fetch");
  call_push_a: assert property ($rose(busy_out) && op == 4'h2 |=>
    fetch_c ##1 valid_program_address_out ##1 stk_c(1'b0, sp) ##1
    stk_c(1'b0, sp - 16'h1) ##1 addr_out == {pb, pc + 16'h2} ##1 idle_c)
    else $error("indexed call order wrong");
  ret_int_a: assert property ($rose(busy_out) && op == 4'h3 |=>
    fetch_c ##1 idle_c [*2] ##1 stk_c(1'b1, sp + 16'h1) ##1
    stk_c(1'b1, sp + 16'h2) ##1 stk_c(1'b1, sp + 16'h3) ##1
    stk_c(1'b1, sp + 16'h4))
    else $error("interrupt return pulls wrong");
  ret_short_a: assert property ($rose(busy_out) && op == 4'h4 |=>
    fetch_c ##1 idle_c [*2] ##1 stk_c(1'b1, sp + 16'h1) ##1
    stk_c(1'b1, sp + 16'h2) ##1 idle_c ##1 done_out)
    else $error("short return order wrong");
  ret_long_a: assert property ($rose(busy_out) && op == 4'h5 |=>
    fetch_c ##1 idle_c [*2] ##1 stk_c(1'b1, sp + 16'h1) ##1
    stk_c(1'b1, sp + 16'h2) ##1 stk_c(1'b1, sp + 16'h3) ##1 done_out)
    else $error("long return order wrong");
  push_rel_a: assert property ($rose(busy_out) && op == 4'h7 |=>
    fetch_c ##3 idle_c ##1 stk_c(1'b0, sp) ##1 stk_c(1'b0, sp - 16'h1))
    else $error("relative push order wrong");
  stack_rel_a: assert property ($rose(busy_out) && op == 4'h8 |=>
    fetch_c ##2 idle_c ##1 valid_data_address_out ##1
    (wide ? valid_data_address_out : done_out))
    else $error("stack relative length wrong");
  int_entry_a: assert property (
    $rose(busy_out) && op == 4'h9 && native |=>
    idle_c [*2] ##1 stk_c(1'b0, sp) ##1 stk_c(1'b0, sp - 16'h1))
    else $error("interrupt entry push wrong");
  int_emul_a: assert property (
    $rose(busy_out) && op == 4'h9 && !native |=>
    idle_c [*3] ##1 stk_c(1'b0, sp) ##1 stk_c(1'b0, sp - 16'h1))
    else $error("emulation entry push wrong");
  vec_read_a: assert property (!vector_pull_n_out |->
    read_write_n_out && valid_data_address_out && addr_out[23:16] == 8'h00)
    else $error("vector pull outside a bank zero read");
  lock_high_a: assert property (memory_lock_n_out)
    else $error("lock asserted");
  done_pulse_a: assert property (done_out |-> !busy_out ##1 !done_out)
    else $error("done not a single pulse");
endmodule // seq_bus_monitor
bind cpu_stack_indirect_bus_sequencer seq_bus_monitor seq_bus_monitor_i (.*);
`default_nettype wire

// ===== verilog/cpu_stack_indirect_bus_sequencer.v
// Bus cycle sequencer for stack and indirect addressing forms
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_consts.vh"
module cpu_stack_indirect_bus_sequencer (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Operation request
  input wire start_in,
  input wire [3:0] op_in,
  input wire native_in,
  input wire wide_in,
  input wire write_in,
  // Processor state
  input wire [15:0] pc_in,
  input wire [7:0] program_bank_in,
  input wire [15:0] sp_in,
  input wire [15:0] direct_base_in,
  input wire [15:0] index_in,
  input wire [15:0] vector_in,
  // Returned read data
  input wire [7:0] rdata_in,
  // Bus outputs
  output reg [23:0] addr_out,
  output reg [7:0] wdata_out,
  output reg read_write_n_out,
  output reg valid_data_address_out,
  output reg valid_program_address_out,
  output reg vector_pull_n_out,
  output reg memory_lock_n_out,
  output reg busy_out,
  output reg done_out
);
  // Sequencer state
  reg active;
  reg [3:0] op;
  reg [3:0] step;
  reg native;
  reg wide;
  reg wr;
  reg [15:0] pc;
  reg [15:0] sp;
  reg [15:0] dp;
  reg [15:0] idx;
  reg [15:0] vec;
  reg [7:0] pbank;
  reg [7:0] status;
  // Bytes gathered from the bus
  reg [7:0] b0;
  reg [7:0] b1;
  reg [7:0] b2;
  // Bytes as they stand once this cycle's read byte is taken
  reg [7:0] next_b0;
  reg [7:0] next_b1;
  reg [7:0] next_b2;
  // Step table lookup
  wire [2:0] kind;
  wire [3:0] src;
  wire [2:0] ofs;
  seq_step_rom u_rom (
    .op_in(op),
    .step_in(step),
    .native_in(native),
    .wide_in(wide),
    .kind_out(kind),
    .src_out(src),
    .ofs_out(ofs)
  );
  // Index of the previous step, used to capture read bytes
  reg [3:0] prev_step;
  reg prev_read;
  // Computed bus address and write byte
  reg [23:0] next_addr;
  reg [7:0] next_wdata;
  reg [15:0] base16;
  reg [15:0] rel;
  // Address compose; 16-bit offsets wrap inside their bank
  always @* begin
    base16 = 16'h0000;
    rel = pc + 16'h0003 + {next_b1, next_b0};
    next_addr = {pbank, pc};
    next_wdata = 8'h00;
    case (src)
      `A_PC: begin
        base16 = pc + {13'h0000, ofs};
        next_addr = {pbank, base16};
      end
      `A_DP: begin
        base16 = dp + {8'h00, next_b0} + {13'h0000, ofs};
        next_addr = {`ZERO_BANK, base16};
      end
      `A_PTR: begin
        base16 = {next_b2, next_b1} + {13'h0000, ofs};
        next_addr = {next_b0, base16};
      end
      `A_SP: begin // Pushes run downward from the stack pointer
        base16 = sp - {13'h0000, ofs};
        // Emulation entry skips the bank slot; pushes still start at S
        if ((op == `OP_INT_ENTRY) && !native) base16 = base16 + 16'h0001;
        next_addr = {`ZERO_BANK, base16};
      end
      `A_SPUP: begin
        base16 = sp + {13'h0000, ofs};
        next_addr = {`ZERO_BANK, base16};
      end
      `A_PBIDX: begin
        base16 = {next_b1, next_b0} + idx + {13'h0000, ofs};
        next_addr = {pbank, base16};
      end
      `A_VEC: begin
        base16 = vec + {13'h0000, ofs};
        next_addr = {`ZERO_BANK, base16};
      end
      `A_NEWPC: begin
        base16 = {next_b1, next_b0};
        next_addr = {pbank, base16};
      end
      `A_SPREL: begin
        base16 = sp + {8'h00, next_b0} + {13'h0000, ofs};
        next_addr = {`ZERO_BANK, base16};
      end
      default: next_addr = {pbank, pc};
    endcase
    // Write data selection
    case (op)
      `OP_CALL_IND: begin // Return counter is the last operand byte
        base16 = pc + 16'h0002;
        next_wdata = (ofs == 3'h0) ? base16[15:8] : base16[7:0];
      end
      `OP_PUSH_IND: next_wdata = (ofs == 3'h0) ? next_b2 : next_b1;
      `OP_PUSH_REL: next_wdata = (ofs == 3'h0) ? rel[15:8] : rel[7:0];
      `OP_INT_ENTRY: begin
        case (ofs)
          3'h0: next_wdata = pbank;
          3'h1: next_wdata = pc[15:8];
          3'h2: next_wdata = pc[7:0];
          default: next_wdata = status;
        endcase
      end
      default: next_wdata = 8'h00;
    endcase
  end
  // Byte of step n is taken at the edge after it appears; step n+1 is
  // issued at that same edge, so the compose reads these forwarded values
  always @* begin
    next_b0 = b0;
    next_b1 = b1;
    next_b2 = b2;
    if (start_in && !active) begin
      // Fresh operation starts from clean bytes
      next_b0 = 8'h00;
      next_b1 = 8'h00;
      next_b2 = 8'h00;
    end else if (prev_read) begin
      case (op)
        `OP_LONG_IND: begin // Offset, then pointer low, high, bank
          if (prev_step == 4'h1) next_b0 = rdata_in;
          else if (prev_step == 4'h2) next_b1 = rdata_in;
          else if (prev_step == 4'h3) next_b2 = rdata_in;
          else if (prev_step == 4'h4) next_b0 = rdata_in;
        end
        `OP_CALL_IND: begin // Operand high byte follows the pushes
          if (prev_step == 4'h1) next_b0 = rdata_in;
          else if (prev_step == 4'h4) next_b1 = rdata_in;
        end
        `OP_PUSH_IND: begin
          if (prev_step == 4'h1) next_b0 = rdata_in;
          else if (prev_step == 4'h2) next_b1 = rdata_in;
          else if (prev_step == 4'h3) next_b2 = rdata_in;
        end
        `OP_STACK_REL: if (prev_step == 4'h1) next_b0 = rdata_in;
        `OP_RET_SHORT: begin
          if (prev_step == 4'h3) next_b0 = rdata_in;
          else if (prev_step == 4'h4) next_b1 = rdata_in;
        end
        `OP_RET_INT: begin
          if (prev_step == 4'h4) next_b0 = rdata_in;
          else if (prev_step == 4'h5) next_b1 = rdata_in;
        end
        default: begin
          if (prev_step == 4'h1) next_b0 = rdata_in;
          else if (prev_step == 4'h2) next_b1 = rdata_in;
        end
      endcase
    end
  end
  // Byte registers
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      b0 <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
    end else begin
      b0 <= next_b0;
      b1 <= next_b1;
      b2 <= next_b2;
    end
  end
  // Step sequencing and registered bus outputs
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      active <= 1'b0;
      op <= 4'h0;
      step <= 4'h0;
      native <= 1'b0;
      wide <= 1'b0;
      wr <= 1'b0;
      pc <= 16'h0000;
      sp <= 16'h0000;
      dp <= 16'h0000;
      idx <= 16'h0000;
      vec <= 16'h0000;
      pbank <= 8'h00;
      status <= 8'h00;
      prev_step <= 4'h0;
      prev_read <= 1'b0;
      addr_out <= 24'h000000;
      wdata_out <= 8'h00;
      read_write_n_out <= 1'b1;
      valid_data_address_out <= 1'b0;
      valid_program_address_out <= 1'b0;
      vector_pull_n_out <= 1'b1;
      memory_lock_n_out <= 1'b1;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      prev_read <= 1'b0;
      if (!active) begin
        // Idle bus: both qualifiers low while nothing runs
        valid_data_address_out <= 1'b0;
        valid_program_address_out <= 1'b0;
        read_write_n_out <= 1'b1;
        vector_pull_n_out <= 1'b1;
        if (start_in) begin
          active <= 1'b1;
          busy_out <= 1'b1;
          op <= op_in;
          step <= 4'h0;
          native <= native_in;
          wide <= wide_in;
          wr <= write_in;
          pc <= pc_in;
          sp <= sp_in;
          dp <= direct_base_in;
          idx <= index_in;
          vec <= vector_in;
          pbank <= program_bank_in;
          status <= rdata_in;
        end
      end else if (kind == `K_END) begin
        active <= 1'b0;
        busy_out <= 1'b0;
        done_out <= 1'b1;
        valid_data_address_out <= 1'b0;
        valid_program_address_out <= 1'b0;
        read_write_n_out <= 1'b1;
        vector_pull_n_out <= 1'b1;
      end else begin
        addr_out <= next_addr;
        wdata_out <= next_wdata;
        step <= step + 4'h1;
        prev_step <= step;
        prev_read <= (kind != `K_DWRITE) && (kind != `K_IDLE);
        vector_pull_n_out <= (kind != `K_VECTOR);
        valid_program_address_out <= (kind == `K_PROG);
        // Qualifiers drop on internal cycles
        valid_data_address_out <= (kind == `K_DREAD) ||
          (kind == `K_DWRITE) || (kind == `K_VECTOR) ||
          ((kind == `K_PROG) && (step == 4'h0) && (op != `OP_INT_ENTRY));
        // Operand stage of stack relative or long indirect may be a store
        read_write_n_out <= !((kind == `K_DWRITE) ||
          ((kind == `K_DREAD) && wr &&
          ((op == `OP_STACK_REL) || (op == `OP_LONG_IND)) &&
          ((src == `A_SPREL) || (src == `A_PTR))));
      end
    end
  end
endmodule // cpu_stack_indirect_bus_sequencer
`default_nettype wire

// ===== verilog/seq_step_rom.v
// Step table: cycle kind, address source and offset per operation step
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_consts.vh"
module seq_step_rom (
  // Lookup
  input wire [3:0] op_in,
  input wire [3:0] step_in,
  input wire native_in,
  input wire wide_in,
  // Result
  output reg [2:0] kind_out,
  output reg [3:0] src_out,
  output reg [2:0] ofs_out
);
  // Combinational table; kind K_END ends the operation and issues no cycle
  always @* begin
    kind_out = `K_END;
    src_out = `A_PC;
    ofs_out = 3'h0;
    case (op_in)
      `OP_LONG_IND: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_DREAD; src_out = `A_DP; end
          4'h3: begin kind_out = `K_DREAD; src_out = `A_DP; ofs_out = 3'h1; end
          4'h4: begin kind_out = `K_DREAD; src_out = `A_DP; ofs_out = 3'h2; end
          4'h5: begin kind_out = `K_DREAD; src_out = `A_PTR; end
          4'h6: begin
            kind_out = wide_in ? `K_DREAD : `K_END;
            src_out = `A_PTR;
            ofs_out = 3'h1;
          end
          default: kind_out = `K_END;
        endcase
      end
      `OP_JMP_IND: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h2; end
          4'h3: begin kind_out = `K_IDLE; src_out = `A_PC; ofs_out = 3'h2; end
          4'h4: begin kind_out = `K_PROG; src_out = `A_PBIDX; end
          4'h5: begin kind_out = `K_PROG; src_out = `A_PBIDX; ofs_out = 3'h1; end
          default: kind_out = `K_END;
        endcase
      end
      `OP_CALL_IND: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_DWRITE; src_out = `A_SP; end
          4'h3: begin kind_out = `K_DWRITE; src_out = `A_SP; ofs_out = 3'h1; end
          4'h4: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h2; end
          4'h5: begin kind_out = `K_IDLE; src_out = `A_PC; ofs_out = 3'h2; end
          4'h6: begin kind_out = `K_PROG; src_out = `A_PBIDX; end
          4'h7: begin kind_out = `K_PROG; src_out = `A_PBIDX; ofs_out = 3'h1; end
          default: kind_out = `K_END;
        endcase
      end
      `OP_RET_INT, `OP_RET_SHORT, `OP_RET_LONG: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_IDLE; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_IDLE; src_out = `A_PC; ofs_out = 3'h1; end
          4'h3: begin kind_out = `K_DREAD; src_out = `A_SPUP; ofs_out = 3'h1; end
          4'h4: begin kind_out = `K_DREAD; src_out = `A_SPUP; ofs_out = 3'h2; end
          4'h5: begin
            // Short return idles at the new counter
            kind_out = (op_in == `OP_RET_SHORT) ? `K_IDLE : `K_DREAD;
            src_out = (op_in == `OP_RET_SHORT) ? `A_NEWPC : `A_SPUP;
            ofs_out = (op_in == `OP_RET_SHORT) ? 3'h0 : 3'h3;
          end
          4'h6: begin
            kind_out = (op_in == `OP_RET_INT) ? `K_DREAD : `K_END;
            src_out = `A_SPUP;
            ofs_out = 3'h4;
          end
          default: kind_out = `K_END;
        endcase
      end
      `OP_PUSH_IND: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_DREAD; src_out = `A_DP; end
          4'h3: begin kind_out = `K_DREAD; src_out = `A_DP; ofs_out = 3'h1; end
          4'h4: begin kind_out = `K_DWRITE; src_out = `A_SP; end
          4'h5: begin kind_out = `K_DWRITE; src_out = `A_SP; ofs_out = 3'h1; end
          default: kind_out = `K_END;
        endcase
      end
      `OP_PUSH_REL: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h2; end
          4'h3: begin kind_out = `K_IDLE; src_out = `A_PC; ofs_out = 3'h2; end
          4'h4: begin kind_out = `K_DWRITE; src_out = `A_SP; end
          4'h5: begin kind_out = `K_DWRITE; src_out = `A_SP; ofs_out = 3'h1; end
          default: kind_out = `K_END;
        endcase
      end
      `OP_STACK_REL: begin
        case (step_in)
          4'h0: begin kind_out = `K_PROG; src_out = `A_PC; end
          4'h1: begin kind_out = `K_PROG; src_out = `A_PC; ofs_out = 3'h1; end
          4'h2: begin kind_out = `K_IDLE; src_out = `A_PC; ofs_out = 3'h1; end
          4'h3: begin kind_out = `K_DREAD; src_out = `A_SPREL; end
          4'h4: begin
            kind_out = wide_in ? `K_DREAD : `K_END;
            src_out = `A_SPREL;
            ofs_out = 3'h1;
          end
          default: kind_out = `K_END;
        endcase
      end
      `OP_INT_ENTRY: begin
        case (step_in)
          4'h0: begin kind_out = `K_IDLE; src_out = `A_PC; end
          4'h1: begin kind_out = `K_IDLE; src_out = `A_PC; end
          4'h2: begin
            // Bank byte is pushed only in native mode
            kind_out = native_in ? `K_DWRITE : `K_IDLE;
            src_out = `A_SP;
          end
          4'h3: begin kind_out = `K_DWRITE; src_out = `A_SP; ofs_out = 3'h1; end
          4'h4: begin kind_out = `K_DWRITE; src_out = `A_SP; ofs_out = 3'h2; end
          4'h5: begin kind_out = `K_DWRITE; src_out = `A_SP; ofs_out = 3'h3; end
          4'h6: begin kind_out = `K_VECTOR; src_out = `A_VEC; end
          4'h7: begin kind_out = `K_VECTOR; src_out = `A_VEC; ofs_out = 3'h1; end
          default: kind_out = `K_END;
        endcase
      end
      default: kind_out = `K_END;
    endcase
  end
endmodule // seq_step_rom
`default_nettype wire
